// ### rtl/hdfc_pkg.sv
package hdfc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned PTR_W = 9;
  // Register offsets
  localparam logic [7:0] BUFFER_CONTROL_ADDR = 8'h02;
  localparam logic [7:0] THRESHOLD_LEVEL_ADDR = 8'h03;
  localparam logic [7:0] FILL_COUNT_ADDR = 8'h04;
  localparam logic [7:0] DATA_PORT_ADDR = 8'h05;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h11;
  // buffer_control fields
  localparam int unsigned DEPTH_SELECT_BIT = 7;
  localparam int unsigned NEAR_FULL_BIT = 6;
  localparam int unsigned NEAR_EMPTY_BIT = 5;
  localparam int unsigned BUFFER_CLEAR_BIT = 4;
  localparam int unsigned THRESHOLD_MSB_BIT = 2;
  localparam int unsigned FILL_MSBS_HI = 1;
  localparam int unsigned FILL_MSBS_LO = 0;
  // Depths
  localparam logic [9:0] DEPTH_SHALLOW = 10'h0FF;
  localparam logic [9:0] DEPTH_DEEP = 10'h200;
  // Interrupt status bits
  localparam int unsigned IRQ_NEAR_FULL = 0;
  localparam int unsigned IRQ_NEAR_EMPTY = 1;
  localparam int unsigned IRQ_OVERRUN = 2;
  localparam int unsigned IRQ_UNDERRUN = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ### rtl/hdfc_store.sv
`timescale 1ns/1ps
module hdfc_store #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned PTR_W = 9
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [PTR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [PTR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);
  // Plain flip-flop storage, no reset needed on contents
  logic [DATA_W-1:0] mem_ff [0:(1<<PTR_W)-1];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
  end

  assign rdata = mem_ff[raddr];
endmodule

// ### rtl/hdfc_top.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// How it works
// - Depth select 1 gives 255, 0 gives 512
// - Near-full when depth minus count <= threshold
// - Near-empty when count <= threshold
// - Clear bit empties buffer, reads zero
// - Threshold MSB used only in deep mode
// - Control bits show fill count bits 9:8
// - Threshold register holds low eight bits
// - Fill count resets zero, push up, pop down
// - Data port address never auto-increments
// - Write pushes byte, read pops oldest
module hdfc_top #(
  parameter int unsigned DATA_W = hdfc_pkg::DATA_W,
  parameter int unsigned PTR_W = hdfc_pkg::PTR_W,
  parameter int unsigned CNT_W = hdfc_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [CNT_W-1:0] hdfc_depth(input logic shallow);
    hdfc_depth = shallow ? hdfc_pkg::DEPTH_SHALLOW : hdfc_pkg::DEPTH_DEEP;
  endfunction

  function automatic logic [PTR_W-1:0] hdfc_next_ptr(input logic [PTR_W-1:0] p,
                                                     input logic shallow);
    logic [CNT_W-1:0] lim;
    lim = hdfc_depth(shallow);
    if ({1'b0, p} == lim - 10'h001) begin
      hdfc_next_ptr = '0;
    end else begin
      hdfc_next_ptr = p + 1'b1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic depth_select_ff;
  logic threshold_msb_ff;
  logic [7:0] threshold_low_bits_ff;
  logic [CNT_W-1:0] count_ff;
  logic [PTR_W-1:0] wptr_ff;
  logic [PTR_W-1:0] rptr_ff;
  logic [hdfc_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [hdfc_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [7:0] reg_rdata_ff;
  logic near_full_d_ff;
  logic near_empty_d_ff;

  logic wr_ctrl;
  logic wr_level;
  logic wr_data;
  logic rd_data;
  logic clear_req;
  logic [CNT_W-1:0] depth;
  logic [CNT_W-1:0] threshold;
  logic full;
  logic empty;
  logic push;
  logic pop;
  logic near_full_flag;
  logic near_empty_flag;
  logic [DATA_W-1:0] head_byte;
  logic [7:0] ctrl_view;

  // Single decoded address per access; the register address never steps
  assign wr_ctrl = reg_wr && (reg_addr == hdfc_pkg::BUFFER_CONTROL_ADDR);
  assign wr_level = reg_wr && (reg_addr == hdfc_pkg::THRESHOLD_LEVEL_ADDR);
  assign wr_data = reg_wr && (reg_addr == hdfc_pkg::DATA_PORT_ADDR);
  assign rd_data = reg_rd && (reg_addr == hdfc_pkg::DATA_PORT_ADDR);
  assign clear_req = wr_ctrl && reg_wdata[hdfc_pkg::BUFFER_CLEAR_BIT];

  assign depth = hdfc_depth(depth_select_ff);
  // Extension bit ignored in shallow mode
  assign threshold = {1'b0, threshold_msb_ff & ~depth_select_ff, threshold_low_bits_ff};
  assign full = (count_ff >= depth);
  assign empty = (count_ff == '0);
  // Overflow write dropped, underflow read pops nothing
  assign push = wr_data && !full;
  assign pop = rd_data && !empty;
  assign near_full_flag = ((depth - count_ff) <= threshold);
  assign near_empty_flag = (count_ff <= threshold);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      depth_select_ff <= hdfc_pkg::CTRL_RESET[hdfc_pkg::DEPTH_SELECT_BIT];
      threshold_msb_ff <= hdfc_pkg::CTRL_RESET[hdfc_pkg::THRESHOLD_MSB_BIT];
    end else if (wr_ctrl) begin
      // Depth change with data stored is the host's hazard
      depth_select_ff <= reg_wdata[hdfc_pkg::DEPTH_SELECT_BIT];
      threshold_msb_ff <= reg_wdata[hdfc_pkg::THRESHOLD_MSB_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      threshold_low_bits_ff <= hdfc_pkg::LEVEL_RESET;
    end else if (wr_level) begin
      threshold_low_bits_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer pointers and count

  hdfc_store #(
    .DATA_W(DATA_W),
    .PTR_W(PTR_W)
  ) u_store (
    .ref_clk(ref_clk),
    .we(push),
    .waddr(wptr_ff),
    .wdata(reg_wdata),
    .raddr(rptr_ff),
    .rdata(head_byte)
  );

  always_ff @(posedge ref_clk) begin
    if (rst || clear_req) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= hdfc_next_ptr(wptr_ff, depth_select_ff);
      end
      if (pop) begin
        rptr_ff <= hdfc_next_ptr(rptr_ff, depth_select_ff);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clear_req) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (pop && !push) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, write one to clear, set beats clear

  logic [hdfc_pkg::IRQ_W-1:0] irq_event;
  logic [hdfc_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_event = '0;
    irq_event[hdfc_pkg::IRQ_NEAR_FULL] = near_full_flag && !near_full_d_ff;
    irq_event[hdfc_pkg::IRQ_NEAR_EMPTY] = near_empty_flag && !near_empty_d_ff;
    irq_event[hdfc_pkg::IRQ_OVERRUN] = wr_data && full;
    irq_event[hdfc_pkg::IRQ_UNDERRUN] = rd_data && empty;
  end

  assign irq_clr = (reg_wr && reg_addr == hdfc_pkg::IRQ_STATUS_ADDR) ?
                   reg_wdata[hdfc_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      near_full_d_ff <= 1'b1;
      near_empty_d_ff <= 1'b1;
    end else begin
      near_full_d_ff <= near_full_flag;
      near_empty_d_ff <= near_empty_flag;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_event;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_mask_ff <= '0;
    end else if (reg_wr && reg_addr == hdfc_pkg::IRQ_MASK_ADDR) begin
      irq_mask_ff <= reg_wdata[hdfc_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    ctrl_view = hdfc_pkg::ZERO_BYTE;
    ctrl_view[hdfc_pkg::DEPTH_SELECT_BIT] = depth_select_ff;
    ctrl_view[hdfc_pkg::NEAR_FULL_BIT] = near_full_flag;
    ctrl_view[hdfc_pkg::NEAR_EMPTY_BIT] = near_empty_flag;
    // Clear bit always reads zero
    ctrl_view[hdfc_pkg::THRESHOLD_MSB_BIT] = threshold_msb_ff;
    ctrl_view[hdfc_pkg::FILL_MSBS_HI] = count_ff[CNT_W-1];
    ctrl_view[hdfc_pkg::FILL_MSBS_LO] = count_ff[CNT_W-2];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_ff <= hdfc_pkg::ZERO_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        hdfc_pkg::BUFFER_CONTROL_ADDR: reg_rdata_ff <= ctrl_view;
        hdfc_pkg::THRESHOLD_LEVEL_ADDR: reg_rdata_ff <= threshold_low_bits_ff;
        hdfc_pkg::FILL_COUNT_ADDR: reg_rdata_ff <= count_ff[7:0];
        // Oldest byte; empty read returns zero
        hdfc_pkg::DATA_PORT_ADDR: reg_rdata_ff <= empty ? hdfc_pkg::ZERO_BYTE : head_byte;
        hdfc_pkg::IRQ_STATUS_ADDR: reg_rdata_ff <= {4'h0, irq_stat_ff};
        hdfc_pkg::IRQ_MASK_ADDR: reg_rdata_ff <= {4'h0, irq_mask_ff};
        default: reg_rdata_ff <= hdfc_pkg::ZERO_BYTE;
      endcase
    end else begin
      reg_rdata_ff <= hdfc_pkg::ZERO_BYTE;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_count_push_up: assert property (@(posedge ref_clk) disable iff (rst)
    (push && !pop && !clear_req) |=> (count_ff == $past(count_ff) + 10'h001))
    else $error("count did not rise on push");

  a_count_pop_down: assert property (@(posedge ref_clk) disable iff (rst)
    (pop && !push && !clear_req) |=> (count_ff == $past(count_ff) - 10'h001))
    else $error("count did not fall on pop");

  a_clear_empties: assert property (@(posedge ref_clk) disable iff (rst)
    clear_req |=> (count_ff == '0) && (wptr_ff == rptr_ff))
    else $error("clear did not empty buffer");

  a_full_drop: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_data && full && !rd_data && !clear_req) |=> $stable(count_ff))
    else $error("write while full changed count");

  a_depth_bound: assert property (@(posedge ref_clk) disable iff (rst)
    depth_select_ff && !$past(!depth_select_ff) |-> count_ff <= hdfc_pkg::DEPTH_SHALLOW)
    else $error("shallow depth exceeded");

  a_near_full_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == hdfc_pkg::BUFFER_CONTROL_ADDR) |=>
      reg_rdata[hdfc_pkg::NEAR_FULL_BIT] == ($past(depth - count_ff) <= $past(threshold)))
    else $error("near-full flag wrong");

  a_near_empty_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == hdfc_pkg::BUFFER_CONTROL_ADDR) |=>
      reg_rdata[hdfc_pkg::NEAR_EMPTY_BIT] == ($past(count_ff) <= $past(threshold)))
    else $error("near-empty flag wrong");

  a_clear_reads_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == hdfc_pkg::BUFFER_CONTROL_ADDR) |=>
      !reg_rdata[hdfc_pkg::BUFFER_CLEAR_BIT])
    else $error("clear bit read nonzero");

  a_fill_msbs: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == hdfc_pkg::BUFFER_CONTROL_ADDR) |=>
      reg_rdata[1:0] == $past(count_ff[9:8]))
    else $error("fill count msbs wrong");

  a_threshold_shallow: assert property (@(posedge ref_clk) disable iff (rst)
    depth_select_ff |-> threshold[8] == 1'b0)
    else $error("threshold msb used in shallow mode");

  a_level_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_level |=> threshold_low_bits_ff == $past(reg_wdata))
    else $error("threshold write lost");

  a_stream_addr: assert property (@(posedge ref_clk) disable iff (rst)
    (push && !clear_req) |=> wptr_ff != $past(wptr_ff))
    else $error("push did not advance");

  // Set must win even when software clears in the same cycle
  a_overrun_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_data && full) |=> irq_stat_ff[hdfc_pkg::IRQ_OVERRUN])
    else $error("overrun event not latched");
endmodule

// ### tb/hdfc_host.sv
`timescale 1ns/1ps
module hdfc_host (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  ////////////////////////////////
  // One strobe cycle; strobes stay up so accesses run back to back
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge ref_clk);
  endtask
  // Idle bus: stale data would hide a missed strobe, so scramble it
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~reg_wdata;
    @(posedge ref_clk);
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, irq;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h9E17;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic rd_d = 1'b0;
  logic ic_req = 1'b0;
  logic [7:0] mq[$];
  logic dsel = 1'b0;
  logic tmsb = 1'b0;
  logic [7:0] tlo = 8'h00;
  logic [3:0] st = 4'h0;
  logic pnf = 1'b1;
  logic pne = 1'b1;
  always #2.5 ref_clk = ~ref_clk;
  hdfc_top hdfc_top_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  hdfc_host hdfc_host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  ////////////////////////////////
  function automatic logic [9:0] depth();
    return dsel ? 10'h0FF : 10'h200;
  endfunction
  function automatic logic [9:0] thr();
    return dsel ? {2'b00, tlo} : {1'b0, tmsb, tlo};
  endfunction
  function automatic logic nf();
    return depth() - 10'(mq.size()) <= thr();
  endfunction
  function automatic logic ne();
    return 10'(mq.size()) <= thr();
  endfunction
  function automatic logic [7:0] ctrl();
    logic [9:0] c;
    c = 10'(mq.size());
    return {dsel, nf(), ne(), 2'b00, tmsb, c[9:8]};
  endfunction
  task automatic upd();
    if (nf() && !pnf) st[0] = 1'b1;
    if (ne() && !pne) st[1] = 1'b1;
    pnf = nf();
    pne = ne();
  endtask
  ////////////////////////////////
  task automatic cmp_rdata(input logic [7:0] x, input logic [7:0] s);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] reg_rdata expected %h seen %h", x, s);
    end
  endtask
  task automatic cmp_irq(input logic x, input logic s);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] irq expected %b seen %b", x, s);
    end
  endtask
  always @(posedge ref_clk) begin
    if (rd_d || ic_req) begin
      e = exp_q.pop_front();
      if (e[8]) cmp_irq(e[0], irq);
      else cmp_rdata(e[7:0], reg_rdata);
    end
    rd_d <= reg_rd;
  end
  ////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hdfc_host_i.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back({1'b0, x});
    hdfc_host_i.acc(1'b0, a, 8'h00);
  endtask
  task automatic see_irq(input logic x);
    hdfc_host_i.idle();
    hdfc_host_i.idle();
    exp_q.push_back({8'h80, x});
    ic_req <= 1'b1;
    @(posedge ref_clk);
    ic_req <= 1'b0;
  endtask
  task automatic push(input logic [7:0] d);
    wr(8'h05, d);
    if (mq.size() < depth()) mq.push_back(d);
    else st[2] = 1'b1;
    upd();
  endtask
  task automatic pop();
    if (mq.size() == 0) begin
      st[3] = 1'b1;
      rd(8'h05, 8'h00);
    end else begin
      rd(8'h05, mq.pop_front());
    end
    upd();
  endtask
  task automatic setc(input logic clr);
    wr(8'h02, {dsel, 2'b00, clr, 1'b0, tmsb, 2'b00});
    if (clr) mq.delete();
    upd();
  endtask
  task automatic setthr(input logic [7:0] v);
    tlo = v;
    wr(8'h03, v);
    upd();
  endtask
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      push(8'($random(seed)));
      rd(8'h02, ctrl());
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h02, ctrl());
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h20, 8'h00);
    pop();
    rd(8'h04, 8'h00);
    wr(8'h11, 8'h00);
    see_irq(1'b0);
    wr(8'h11, 8'h08);
    rd(8'h11, 8'h08);
    see_irq(1'b1);
    wr(8'h10, 8'h08);
    st[3] = 1'b0;
    see_irq(1'b0);
    tmsb = 1'b1;
    setc(1'b0);
    setthr(8'($random(seed)));
    rd(8'h03, tlo);
    fill(513);
    rd(8'h04, 8'h00);
    rd(8'h10, {4'h0, st});
    for (int i = 0; i < 513; i++) begin
      pop();
      rd(8'h04, 8'(mq.size()));
    end
    rd(8'h10, {4'h0, st});
    wr(8'h10, 8'h0F);
    st = 4'h0;
    push(8'hA5);
    push(8'h5A);
    setc(1'b1);
    rd(8'h04, 8'h00);
    rd(8'h02, ctrl());
    // Extension bit left set so shallow mode must ignore it
    setc(1'b1);
    dsel = 1'b1;
    // Depth only changes on an empty buffer
    setc(1'b0);
    setthr(8'($random(seed)));
    fill(256);
    rd(8'h04, 8'hFF);
    pop();
    pop();
    rd(8'h10, {4'h0, st});
    hdfc_host_i.idle();
    // Mid-run reset brings every register back to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    mq.delete();
    dsel = 1'b0;
    tmsb = 1'b0;
    tlo = 8'h00;
    @(posedge ref_clk);
    rd(8'h04, 8'h00);
    rd(8'h02, ctrl());
    rd(8'h03, 8'h00);
    rd(8'h10, 8'h00);
    see_irq(1'b0);
    repeat (3) @(posedge ref_clk);
    if (exp_q.size() != 0) num_errors++;
    stop_test();
  end
endmodule
